// file: design/chc_defines.svh
`ifndef CHC_DEFINES_SVH
`define CHC_DEFINES_SVH
// Overview of operation
// (RULE_01) Watchdog kick bit 6 self-clears after restart
// (RULE_02) Charge needs pin low, bit set, current nonzero
// (RULE_03) Control bit 4 enables charge, default 1
// (RULE_04) Control bit 7 forbids pulse mode, default 0
// (RULE_05) Bits 3:1 select minimum system voltage, default 101
// (RULE_06) Fast charge bits 5:0, 20 mA/LSB, default 010001
// (RULE_07) Top four fast charge codes map nonlinearly
// (RULE_08) Fast charge code zero disables charging
// (RULE_09) Input limit over 700 mA forces FET full on
// (RULE_10) Bit 6 low: partial FET below 700 mA
// (RULE_11) Precharge bits 7:4, 20 mA offset, default 0001
// (RULE_12) Precharge codes above 1100 clamp to 1100
// (RULE_13) Termination bits 3:0, 20 mA offset, default 0010
// (RULE_14) Termination codes above 1100 clamp to 1100
// (RULE_15) Control register at 01h resets to 1Ah
// (RULE_16) Current register at 02h resets to 91h
// (RULE_17) Pre/term register at 03h resets to 12h
// (RULE_18) Watchdog restores only its listed fields
`define CHC_ADDR_CTRL     8'h01
`define CHC_ADDR_FAST_CHARGE_CURRENT     8'h02
`define CHC_ADDR_PRETERM  8'h03
`define CHC_RST_CTRL      8'h1a
`define CHC_RST_FAST_CHARGE_CURRENT      8'h91
`define CHC_RST_PRETERM   8'h12
`define CHC_WDM_CTRL      8'h50
`define CHC_WDM_FAST_CHARGE_CURRENT      8'h3f
`define CHC_WDM_PRETERM   8'hff
`define CHC_BIT_PULSE_MODE_DISABLE   7
`define CHC_BIT_KICK      6
`define CHC_BIT_CHG_EN    4
`define CHC_BIT_FULL_ON   6
`define CHC_SYSV_MSB      3
`define CHC_SYSV_LSB      1
`define CHC_FAST_CHARGE_CURRENT_MSB      5
`define CHC_FAST_CHARGE_CURRENT_LSB      0
`define CHC_PRE_MSB       7
`define CHC_PRE_LSB       4
`define CHC_TRM_MSB       3
`define CHC_TRM_LSB       0
`define CHC_TERM_MAX      4'hc
`define CHC_IIN_700MA     5'h06
`define CHC_BITS_BYTE     4'h8
`endif

// file: design/chc_pkg.sv
package chc_pkg;
  typedef enum logic [6:0] {
    CHC_IDLE   = 7'b0000001,
    CHC_ADDR   = 7'b0000010,
    CHC_AACK   = 7'b0000100,
    CHC_WRITE  = 7'b0001000,
    CHC_WACK   = 7'b0010000,
    CHC_READ   = 7'b0100000,
    CHC_RACK   = 7'b1000000
  } chc_state_e;
endpackage : chc_pkg

// file: design/chc_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "chc_defines.svh"
module chc_config_regs
  import chc_pkg::*;
#(
  // Bus address value is arbitrary
  parameter logic [6:0] DEV_ADDR = 7'h55
) (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  input  wire logic       ce_n_in,
  input  wire logic [4:0] input_current_limit_in,
  input  wire logic       watchdog_expire_in,
  input  wire logic       reg_reset_in,
  output logic            watchdog_kick_out,
  output logic            charge_enable_out,
  output logic            pulse_mode_disable_out,
  output logic [2:0]      min_system_voltage_out,
  output logic [5:0]      fast_charge_current_out,
  output logic            blocking_fet_full_on_out,
  output logic [3:0]      precharge_current_out,
  output logic [3:0]      termination_current_out
);

  localparam logic [7:0] RST_VAL [3] = '{`CHC_RST_CTRL, `CHC_RST_FAST_CHARGE_CURRENT,
                                         `CHC_RST_PRETERM};
  localparam logic [7:0] WD_MASK [3] = '{`CHC_WDM_CTRL, `CHC_WDM_FAST_CHARGE_CURRENT,
                                         `CHC_WDM_PRETERM};

  // Pin synchronisers: stage 1 is read only by stage 2
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic [2:0] ce_sync;
  logic       scl_f;
  logic       sda_f;
  logic       ce_n_f;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      ce_sync  <= 3'h7;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      ce_n_f   <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      ce_sync  <= {ce_sync[1:0], ce_n_in};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
      if (ce_sync[1] == ce_sync[2]) begin
        ce_n_f <= ce_sync[2];
      end
    end
  end

  // Filtered values of the previous cycle give the bus events
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  wire scl_rise  = scl_f & ~scl_q;
  wire scl_fall  = ~scl_f & scl_q;
  wire bus_start = scl_f & scl_q & sda_q & ~sda_f;
  wire bus_stop  = scl_f & scl_q & ~sda_q & sda_f;

  chc_state_e state;
  chc_state_e next_state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic       rd_mode;
  logic       first;
  logic       nack;
  logic [7:0] cfg [3];

  wire byte_done = (bit_cnt == `CHC_BITS_BYTE);
  wire [7:0] rx_byte = shift;
  wire addr_hit = (rx_byte[7:1] == DEV_ADDR);
  wire ptr_ok = (ptr >= `CHC_ADDR_CTRL) && (ptr <= `CHC_ADDR_PRETERM);
  wire [1:0] ptr_idx = 2'(ptr - `CHC_ADDR_CTRL);
  // Unmapped pointers read as zero and ignore writes
  wire [7:0] rd_data = ptr_ok ? cfg[ptr_idx] : 8'h00;
  wire wr_fire = (state == CHC_WRITE) & scl_fall & byte_done & ~first;

  always_comb begin
    next_state = state;
    case (state)
      CHC_IDLE: next_state = CHC_IDLE;
      CHC_ADDR: begin
        if (scl_fall && byte_done) begin
          next_state = addr_hit ? CHC_AACK : CHC_IDLE;
        end
      end
      CHC_AACK: begin
        if (scl_fall) begin
          next_state = rd_mode ? CHC_READ : CHC_WRITE;
        end
      end
      CHC_WRITE: begin
        if (scl_fall && byte_done) begin
          next_state = CHC_WACK;
        end
      end
      CHC_WACK: begin
        if (scl_fall) begin
          next_state = CHC_WRITE;
        end
      end
      CHC_READ: begin
        if (scl_fall && byte_done) begin
          next_state = CHC_RACK;
        end
      end
      CHC_RACK: begin
        if (scl_fall) begin
          next_state = nack ? CHC_IDLE : CHC_READ;
        end
      end
      default: next_state = CHC_IDLE;
    endcase
    if (bus_stop) begin
      next_state = CHC_IDLE;
    end
    if (bus_start) begin
      next_state = CHC_ADDR;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= CHC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bit counter and receive shifter
  // The ninth clock of a byte is the acknowledge and must not be counted
  wire ack_slot = (state == CHC_AACK) | (state == CHC_WACK) |
                  (state == CHC_RACK);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
    end else if (bus_start || (scl_fall && byte_done)) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise && !ack_slot) begin
      bit_cnt <= bit_cnt + 4'h1;
      shift   <= {shift[6:0], sda_f};
    end
  end

  // Transfer direction is the last bit of the address byte
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_mode <= 1'b0;
    end else if ((state == CHC_ADDR) && scl_fall && byte_done) begin
      rd_mode <= rx_byte[0];
    end
  end

  // Host acknowledge after a read byte; high ends the read
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nack <= 1'b1;
    end else if ((state == CHC_RACK) && scl_rise) begin
      nack <= sda_f;
    end
  end

  // Pointer and transmit byte; reads auto-increment the pointer
  wire load_tx = scl_fall & (((state == CHC_AACK) & rd_mode) |
                             ((state == CHC_RACK) & ~nack));

  // Transmit byte: loaded at the read address acknowledge and at each host ACK of a read byte, shifted out MSB first
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx <= 8'hff;
    end else if (load_tx) begin
      tx <= rd_data;
    end else if ((state == CHC_READ) && scl_fall) begin
      tx <= {tx[6:0], 1'b1};
    end
  end

  // First written byte is the pointer, later bytes advance it
  wire wr_byte_end = (state == CHC_WRITE) & scl_fall & byte_done;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ptr   <= 8'h00;
      first <= 1'b0;
    end else begin
      if (load_tx) begin
        ptr <= ptr + 8'h01;
      end else if (wr_byte_end) begin
        ptr <= first ? rx_byte : ptr + 8'h01;
      end
      if ((state == CHC_AACK) && scl_fall) begin
        first <= 1'b1;
      end else if (wr_byte_end) begin
        first <= 1'b0;
      end
    end
  end

  // Open drain: only ever pulls low, enable active low
  wire pull_low = (state == CHC_AACK) | (state == CHC_WACK) |
                  ((state == CHC_READ) & ~tx[7]);
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~pull_low;

  // Register file; register reset beats watchdog beats host write
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cfg
      wire hit = wr_fire & ptr_ok & (ptr_idx == 2'(gi));
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          cfg[gi] <= RST_VAL[gi]; // [RULE_15] [RULE_16] [RULE_17]
        end else if (reg_reset_in) begin
          cfg[gi] <= RST_VAL[gi]; // [RULE_15] [RULE_16] [RULE_17]
        end else if (watchdog_expire_in) begin
          cfg[gi] <= (cfg[gi] & ~WD_MASK[gi]) |
                     (RST_VAL[gi] & WD_MASK[gi]); // [RULE_18]
        end else if (hit) begin
          cfg[gi] <= rx_byte;
        end else if (gi == 0) begin
          // Kick bit lives one cycle, then the timer has been restarted
          cfg[gi][`CHC_BIT_KICK] <= 1'b0; // [RULE_01]
        end
      end
    end
  endgenerate

  wire [5:0] fast_charge_current    = cfg[1][`CHC_FAST_CHARGE_CURRENT_MSB:`CHC_FAST_CHARGE_CURRENT_LSB]; // [RULE_06] [RULE_07]
  wire [3:0] pre_raw = cfg[2][`CHC_PRE_MSB:`CHC_PRE_LSB];
  wire [3:0] trm_raw = cfg[2][`CHC_TRM_MSB:`CHC_TRM_LSB];
  wire [2:0] sysv_code = cfg[0][`CHC_SYSV_MSB:`CHC_SYSV_LSB]; // [RULE_05]
  // Core decodes codes 111100..111111 to its own current steps
  wire chg_ok = ~ce_n_f & cfg[0][`CHC_BIT_CHG_EN] &
                (fast_charge_current != 6'h00); // [RULE_02] [RULE_03] [RULE_08]
  wire full_on = (input_current_limit_in > `CHC_IIN_700MA) |
                 cfg[1][`CHC_BIT_FULL_ON]; // [RULE_09] [RULE_10]
  // Clamp here so the core never sees a code beyond its top step
  wire [3:0] pre_clamp = (pre_raw > `CHC_TERM_MAX) ? `CHC_TERM_MAX :
                         pre_raw; // [RULE_11] [RULE_12]
  wire [3:0] trm_clamp = (trm_raw > `CHC_TERM_MAX) ? `CHC_TERM_MAX :
                         trm_raw; // [RULE_13] [RULE_14]

  // Control outputs
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      watchdog_kick_out      <= 1'b0;
      charge_enable_out      <= 1'b0;
      pulse_mode_disable_out <= 1'b0;
      min_system_voltage_out <= 3'h0;
    end else begin
      watchdog_kick_out      <= cfg[0][`CHC_BIT_KICK]; // [RULE_01]
      charge_enable_out      <= chg_ok; // [RULE_02]
      pulse_mode_disable_out <= cfg[0][`CHC_BIT_PULSE_MODE_DISABLE]; // [RULE_04]
      min_system_voltage_out <= sysv_code; // [RULE_05]
    end
  end

  // Current setpoints
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fast_charge_current_out  <= 6'h00;
      blocking_fet_full_on_out <= 1'b0;
      precharge_current_out    <= 4'h0;
      termination_current_out  <= 4'h0;
    end else begin
      fast_charge_current_out  <= fast_charge_current; // [RULE_06]
      blocking_fet_full_on_out <= full_on; // [RULE_09]
      precharge_current_out    <= pre_clamp; // [RULE_12]
      termination_current_out  <= trm_clamp; // [RULE_14]
    end
  end

endmodule : chc_config_regs
`default_nettype wire

// file: sim/chc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module chc_host_model (
  input  wire logic clk_in,
  input  wire logic sda_oe_n_in,
  input  wire logic sda_drv_in,
  output logic      scl_out,
  output logic      sda_out
);
  logic pull = 1'b0;
  // Pull-up line: either side pulling low wins
  assign sda_out = ~pull & (sda_oe_n_in | sda_drv_in);
  initial scl_out = 1'b1;
  task automatic hp;
    repeat (10) @(negedge clk_in);
  endtask : hp
  // Short wait first so the synced SDA never moves while the synced SCL is high
  task automatic bit_x(input logic b, output logic r);
    repeat (3) @(negedge clk_in);
    pull = ~b;
    hp;
    scl_out = 1'b1;
    hp;
    r = sda_out;
    scl_out = 1'b0;
  endtask : bit_x
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(1'b1, a);
  endtask : byte_x
  task automatic start;
    hp;
    pull = 1'b0;
    hp;
    scl_out = 1'b1;
    hp;
    pull = 1'b1;
    hp;
    scl_out = 1'b0;
  endtask : start
  task automatic stop;
    hp;
    pull = 1'b1;
    hp;
    scl_out = 1'b1;
    hp;
    pull = 1'b0;
    hp;
  endtask : stop
endmodule : chc_host_model
`default_nettype wire

// file: sim/chc_config_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module chc_config_monitor (
  input wire logic       clk_in,
  input wire logic       resetn_in,
  input wire logic       ce_n_in,
  input wire logic [4:0] input_current_limit_in,
  input wire logic       watchdog_expire_in,
  input wire logic       reg_reset_in,
  input wire logic       watchdog_kick_out,
  input wire logic       charge_enable_out,
  input wire logic       pulse_mode_disable_out,
  input wire logic [2:0] min_system_voltage_out,
  input wire logic [5:0] fast_charge_current_out,
  input wire logic       blocking_fet_full_on_out,
  input wire logic [3:0] precharge_current_out,
  input wire logic [3:0] termination_current_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_kick;
    watchdog_kick_out |=> !watchdog_kick_out;
  endproperty
  a_kick: assert property (p_kick)
    else $error("kick pulse too long");
  property p_ce_off;
    ce_n_in [*6] |-> !charge_enable_out;
  endproperty
  a_ce_off: assert property (p_ce_off)
    else $error("charging with pin high");
  property p_zero_off;
    fast_charge_current_out == 6'h0 |-> !charge_enable_out;
  endproperty
  a_zero_off: assert property (p_zero_off)
    else $error("charging at zero current");
  property p_fet_over;
    input_current_limit_in > 5'h6 |=> blocking_fet_full_on_out;
  endproperty
  a_fet_over: assert property (p_fet_over)
    else $error("fet not full on");
  property p_clamp;
    precharge_current_out <= 4'hc && termination_current_out <= 4'hc;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("current code not clamped");
  property p_defaults;
    $rose(resetn_in) |=> min_system_voltage_out == 3'h5
      && fast_charge_current_out == 6'h11 && !pulse_mode_disable_out
      && {precharge_current_out, termination_current_out} == 8'h12;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("bad value after reset");
  property p_wd_restore;
    watchdog_expire_in && !reg_reset_in |-> ##2 fast_charge_current_out == 6'h11
      && {precharge_current_out, termination_current_out} == 8'h12;
  endproperty
  a_wd_restore: assert property (p_wd_restore)
    else $error("watchdog did not restore");
  property p_wd_keep;
    watchdog_expire_in && !reg_reset_in |-> ##2
      $stable(min_system_voltage_out) && $stable(pulse_mode_disable_out);
  endproperty
  a_wd_keep: assert property (p_wd_keep)
    else $error("watchdog touched kept field");
endmodule : chc_config_monitor
bind chc_config_regs chc_config_monitor chc_config_monitor_inst (.*);
`default_nettype wire

// file: sim/chc_config_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
module chc_config_regs_test;
  logic       clk_in = 1'b0;
  logic       resetn_in = 1'b0;
  logic       ce_n = 1'b0;
  logic       wd_exp = 1'b0;
  logic       reg_rst = 1'b0;
  logic [4:0] ilim = 5'h0;
  logic       scl, sda, oe_n, kick, chg, pulse_frequency_mode, fet;
  logic       sda_drv;
  logic [2:0] sysv;
  logic [5:0] fast;
  logic [3:0] pre, term;
  int         fail_count = 0;
  int         n_compared = 0;
  int         kick_n = 0;
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) kick_n <= kick_n + 32'(kick);
  chc_host_model host_inst (.clk_in(clk_in), .sda_oe_n_in(oe_n),
    .sda_drv_in(sda_drv), .scl_out(scl), .sda_out(sda));
  chc_config_regs chc_config_regs_inst (.clk_in(clk_in),
    .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv),
    .sda_oe_n_out(oe_n), .ce_n_in(ce_n), .input_current_limit_in(ilim),
    .watchdog_expire_in(wd_exp), .reg_reset_in(reg_rst),
    .watchdog_kick_out(kick), .charge_enable_out(chg),
    .pulse_mode_disable_out(pulse_frequency_mode), .min_system_voltage_out(sysv),
    .fast_charge_current_out(fast), .blocking_fet_full_on_out(fet),
    .precharge_current_out(pre), .termination_current_out(term));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    host_inst.start;
    host_inst.byte_x(8'haa, q);
    host_inst.byte_x(p, q);
    host_inst.byte_x(d, q);
    host_inst.stop;
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [7:0] q);
    host_inst.start;
    host_inst.byte_x(8'haa, q);
    host_inst.byte_x(p, q);
    host_inst.start;
    host_inst.byte_x(8'hab, q);
    host_inst.byte_x(8'hff, q);
    host_inst.stop;
  endtask : rd
  task automatic t_reset;
    logic [7:0] q;
    rd(8'h01, q);
    chk(q, 8'h1a);
    rd(8'h02, q);
    chk(q, 8'h91);
    rd(8'h03, q);
    chk(q, 8'h12);
    chk({pulse_frequency_mode, sysv, 3'h0, chg}, 8'h51);
    chk({2'h0, fast}, 8'h11);
    chk({pre, term}, 8'h12);
    $display("reset test done");
  endtask : t_reset
  task automatic t_ctrl;
    logic [7:0] q;
    int         k;
    k = kick_n;
    wr(8'h01, 8'h5a);
    chk(8'(kick_n - k), 8'h1);
    rd(8'h01, q);
    chk(q, 8'h1a);
    wr(8'h01, 8'h8e);
    chk({pulse_frequency_mode, sysv, 3'h0, chg}, 8'hf0);
    ce_n = 1'b1;
    wr(8'h01, 8'h10);
    chk({7'h0, chg}, 8'h0);
    ce_n = 1'b0;
    repeat (8) @(negedge clk_in);
    chk({pulse_frequency_mode, sysv, 3'h0, chg}, 8'h01);
    $display("control test done");
  endtask : t_ctrl
  task automatic t_cur;
    wr(8'h02, 8'h3c);
    chk({2'h0, fast}, 8'h3c);
    wr(8'h02, 8'h00);
    chk({fast, 1'b0, chg}, 8'h0);
    ilim = 5'h7;
    repeat (2) @(negedge clk_in);
    chk({7'h0, fet}, 8'h1);
    ilim = 5'h6;
    repeat (2) @(negedge clk_in);
    chk({7'h0, fet}, 8'h0);
    wr(8'h02, 8'h7f);
    chk({fet, 1'b0, fast}, 8'hbf);
    $display("current test done");
  endtask : t_cur
  task automatic t_wd;
    logic [7:0] q;
    wr(8'h03, 8'hdf);
    chk({pre, term}, 8'hcc);
    wr(8'h01, 8'h8e);
    wd_exp = 1'b1;
    @(negedge clk_in);
    wd_exp = 1'b0;
    repeat (2) @(negedge clk_in);
    chk({pre, term}, 8'h12);
    chk({pulse_frequency_mode, sysv, fet, fast[2:0]}, 8'hf9);
    chk({2'h0, fast}, 8'h11);
    rd(8'h01, q);
    chk(q, 8'h9e);
    reg_rst = 1'b1;
    @(negedge clk_in);
    reg_rst = 1'b0;
    rd(8'h02, q);
    chk(q, 8'h91);
    chk({pulse_frequency_mode, sysv, fet, 3'h0}, 8'h50);
    $display("watchdog test done");
  endtask : t_wd
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  // About fifteen transfers of under a thousand cycles each
  initial begin
    #400000;
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (20) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (10) @(negedge clk_in);
    t_reset;
    t_ctrl;
    t_cur;
    t_wd;
    end_sim;
  end
endmodule : chc_config_regs_test
`default_nettype wire
